// ==== core/clk_gate_pkg.sv ====
// Constants for the peripheral clock gating bank: register map, field positions, reset values.
// Assumes a single 50 MHz clock and an APB register port with 32-bit data.
// Function
// R1: Each writable gating bit enables the clock of exactly one peripheral unit.
// R2: A set gating bit passes the unit's clock so it runs normally.
// R3: A cleared gating bit stops the unit's clock and holds it disabled.
// R4: Bus access to a unit whose clock is gated off answers with a fault.
// R5: All gating bits read zero after reset; every unit starts unclocked.
// R6: Deep-sleep gating register sits at offset 0x124, 32 bits wide.
// R7: Run, sleep and deep-sleep gating registers exist; power mode selects one.
// R8: Sleep and deep-sleep registers apply only while automatic gating is enabled.
// R9: Comparators at 25,24; timers 19..16; two-wire 14,12; sync serial 5,4; UARTs 1,0.
// R10: Unused bits read zero, are read-only and ignore writes.
// R11: Without automatic gating the run register applies in every power mode.
package clk_gate_pkg;

  localparam int ADDR_W = 12;
  localparam int NUM_UNITS = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h104;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [ADDR_W-1:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [ADDR_W-1:0] CLK_CFG_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h204;
  localparam logic [ADDR_W-1:0] EFFECTIVE_OFS = 12'h208;

  // Gating field positions
  localparam int COMPARATOR_B_POS = 25;
  localparam int COMPARATOR_A_POS = 24;
  localparam int GP_COUNTER_D_POS = 19;
  localparam int GP_COUNTER_C_POS = 18;
  localparam int GP_COUNTER_B_POS = 17;
  localparam int GP_COUNTER_A_POS = 16;
  localparam int TWO_WIRE_B_POS = 14;
  localparam int TWO_WIRE_A_POS = 12;
  localparam int SYNC_SERIAL_B_POS = 5;
  localparam int SYNC_SERIAL_A_POS = 4;
  localparam int ASYNC_SERIAL_B_POS = 1;
  localparam int ASYNC_SERIAL_A_POS = 0;

  // Writable bits of each gating register
  localparam logic [31:0] GATE_WR_MASK = 32'h030F_5033;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  // Clock configuration field and reset
  localparam int AUTO_GATE_POS = 27;
  localparam logic [31:0] CLK_CFG_RESET = 32'h0000_0000;

  // Interrupt status bits
  localparam int IRQ_FAULT_POS = 0;
  localparam int IRQ_MODE_POS = 1;
  localparam logic [31:0] IRQ_WR_MASK = 32'h0000_0003;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_t;

  // Gather the 12 gating bits from a 32-bit register image, lowest unit first
  function automatic logic [NUM_UNITS-1:0] pack_units(input logic [31:0] r);
    pack_units = {r[COMPARATOR_B_POS], r[COMPARATOR_A_POS], r[GP_COUNTER_D_POS], r[GP_COUNTER_C_POS],
                  r[GP_COUNTER_B_POS], r[GP_COUNTER_A_POS], r[TWO_WIRE_B_POS], r[TWO_WIRE_A_POS],
                  r[SYNC_SERIAL_B_POS], r[SYNC_SERIAL_A_POS], r[ASYNC_SERIAL_B_POS], r[ASYNC_SERIAL_A_POS]};
  endfunction

endpackage

// ==== core/deep_sleep_clock_gating_bank.sv ====
// Peripheral clock gating bank with run, sleep and deep-sleep gating registers.
// Assumes an APB master on clk, powerMode from the power manager on the same clock,
// and a peripheral access request (periphSel/periphAccess) from the system bus fabric.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module deep_sleep_clock_gating_bank
  import clk_gate_pkg::*;
#(
  parameter int UNITS = clk_gate_pkg::NUM_UNITS
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [clk_gate_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [1:0] powerMode, // Current power mode
  input wire logic [UNITS-1:0] periphSel, // One-hot unit targeted by a bus access
  input wire logic periphAccess, // Access strobe for periphSel
  output logic [UNITS-1:0] unitClkEn, // Effective per-unit clock enables
  output logic [UNITS-1:0] unitClk, // Gated per-unit clocks
  output logic periphFault, // Bus fault for the unit access of the previous cycle
  output logic irq // Level interrupt
);
  import clk_gate_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] runGate;
  logic [31:0] sleepGate;
  logic [31:0] deepGate;
  logic [31:0] clkCfg;
  logic [31:0] irqStatus;
  logic [31:0] irqMask;
  logic [UNITS-1:0] effEnable;
  logic [31:0] readData;
  logic readyQ;
  logic errQ;
  logic irqQ;
  logic faultQ;
  logic [1:0] modeQ;
  logic [31:0] next_runGate;
  logic [31:0] next_sleepGate;
  logic [31:0] next_deepGate;
  logic [31:0] next_clkCfg;
  logic [31:0] next_irqStatus;
  logic [31:0] next_irqMask;
  logic [UNITS-1:0] next_effEnable;
  logic [31:0] next_readData;
  logic next_readyQ;
  logic next_errQ;
  logic next_irqQ;
  logic next_faultQ;
  logic [1:0] next_modeQ;

  logic setupPhase;
  logic writeNow;
  logic addrHit;
  logic [31:0] strbMask;
  logic faultNow;
  logic [UNITS-1:0] selEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: merge a write into writable bits only, under byte strobes
  function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [31:0] bm, input logic [31:0] wm);
    merge_wr = (old & ~(bm & wm)) | (wd & bm & wm);
  endfunction

  // Byte strobes widened to a bit mask
  always_comb begin
    strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // Slave answers in the setup-to-access step: ready in the first access cycle
  always_comb begin
    setupPhase = psel && !penable;
    writeNow = setupPhase && pwrite;
  end

  // Address decode; unmapped addresses are flagged as errors
  always_comb begin
    case (paddr)
      RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS, CLK_CFG_OFS,
      IRQ_STATUS_OFS, IRQ_MASK_OFS, EFFECTIVE_OFS: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection: pick which gating register drives the units
  always_comb begin
    if (!clkCfg[AUTO_GATE_POS]) begin
      selEnable = pack_units(runGate); // [R8] [R11]
    end else begin
      case (power_mode_t'(modeQ))
        MODE_SLEEP: selEnable = pack_units(sleepGate); // [R7]
        MODE_DEEP: selEnable = pack_units(deepGate); // [R7]
        default: selEnable = pack_units(runGate); // [R7]
      endcase
    end
  end

  // Fault decision against the enables now in force
  fault_gate #(
    .UNITS(UNITS)
  ) u_fault (
    .unitSel(periphAccess ? periphSel : '0),
    .unitEnable(effEnable),
    .fault(faultNow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state for registers, interrupts and APB answer
  always_comb begin
    next_runGate = runGate;
    next_sleepGate = sleepGate;
    next_deepGate = deepGate;
    next_clkCfg = clkCfg;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    next_readData = readData;
    next_readyQ = 1'b0;
    next_errQ = 1'b0;
    next_modeQ = powerMode;
    next_effEnable = selEnable; // [R1]
    next_faultQ = faultNow; // [R4]

    if (setupPhase) begin
      next_readyQ = 1'b1;
      next_errQ = !addrHit;
      next_readData = 32'h0000_0000;
    end

    // Writes touch only writable bits; reserved bits stay zero
    if (writeNow && addrHit) begin
      case (paddr)
        RUN_GATE_OFS: next_runGate = merge_wr(runGate, pwdata, strbMask, GATE_WR_MASK); // [R10]
        SLEEP_GATE_OFS: next_sleepGate = merge_wr(sleepGate, pwdata, strbMask, GATE_WR_MASK); // [R10]
        DEEP_GATE_OFS: next_deepGate = merge_wr(deepGate, pwdata, strbMask, GATE_WR_MASK); // [R6] [R9] [R10]
        CLK_CFG_OFS: next_clkCfg[AUTO_GATE_POS] = strbMask[AUTO_GATE_POS] ? pwdata[AUTO_GATE_POS] :
                                                  clkCfg[AUTO_GATE_POS];
        IRQ_MASK_OFS: next_irqMask = merge_wr(irqMask, pwdata, strbMask, IRQ_WR_MASK);
        IRQ_STATUS_OFS: next_irqStatus = irqStatus & ~(pwdata & strbMask & IRQ_WR_MASK);
        default: next_irqMask = irqMask;
      endcase
    end

    // Reads return the stored image; reserved bits are always zero
    if (setupPhase && !pwrite && addrHit) begin
      case (paddr)
        RUN_GATE_OFS: next_readData = runGate & GATE_WR_MASK;
        SLEEP_GATE_OFS: next_readData = sleepGate & GATE_WR_MASK;
        DEEP_GATE_OFS: next_readData = deepGate & GATE_WR_MASK; // [R6] [R10]
        CLK_CFG_OFS: next_readData = clkCfg;
        IRQ_STATUS_OFS: next_readData = irqStatus;
        IRQ_MASK_OFS: next_readData = irqMask;
        EFFECTIVE_OFS: next_readData = {{(32-UNITS){1'b0}}, effEnable};
        default: next_readData = 32'h0000_0000;
      endcase
    end

    // Events set after the clear so that a coinciding event wins
    if (faultNow) begin
      next_irqStatus[IRQ_FAULT_POS] = 1'b1; // [R4]
    end
    if (modeQ != powerMode) begin
      next_irqStatus[IRQ_MODE_POS] = 1'b1;
    end

    next_irqQ = |(next_irqStatus & irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; all gating bits clear at reset so every unit starts stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      runGate <= GATE_RESET; // [R5]
      sleepGate <= GATE_RESET; // [R5]
      deepGate <= GATE_RESET; // [R5]
      clkCfg <= CLK_CFG_RESET;
      irqStatus <= 32'h0000_0000;
      irqMask <= 32'h0000_0000;
      effEnable <= '0; // [R5]
      readData <= 32'h0000_0000;
      readyQ <= 1'b0;
      errQ <= 1'b0;
      irqQ <= 1'b0;
      faultQ <= 1'b0;
      modeQ <= 2'h0;
    end else begin
      runGate <= next_runGate;
      sleepGate <= next_sleepGate;
      deepGate <= next_deepGate;
      clkCfg <= next_clkCfg;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      effEnable <= next_effEnable;
      readData <= next_readData;
      readyQ <= next_readyQ;
      errQ <= next_errQ;
      irqQ <= next_irqQ;
      faultQ <= next_faultQ;
      modeQ <= next_modeQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit clock gates driven by the registered enables
  for (genvar g = 0; g < UNITS; g++) begin : gen_gate
    unit_clock_gate u_gate (
      .clkIn(clk),
      .enable(effEnable[g]),
      .clkOut(unitClk[g])
    );
  end

  // Outputs from flip-flops
  always_comb begin
    prdata = readData;
    pready = readyQ;
    pslverr = errQ;
    irq = irqQ;
    periphFault = faultQ;
    unitClkEn = effEnable; // [R1] [R2] [R3]
  end
endmodule

// ==== core/fault_gate.sv ====
// Fault decision for accesses that target peripheral units.
// Assumes unitSel is one-hot or zero, from the system address decoder.
`timescale 1ns/1ps
module fault_gate #(
  parameter int UNITS = 12
) (
  input wire logic [UNITS-1:0] unitSel, // Unit targeted by current access
  input wire logic [UNITS-1:0] unitEnable, // Effective clock enables
  output logic fault // Access hits a stopped unit
);
  // A stopped unit cannot answer, so the access must be faulted instead of hanging
  always_comb begin
    fault = |(unitSel & ~unitEnable); // [R4]
  end
endmodule

// ==== core/unit_clock_gate.sv ====
// Glitch-free clock gate for one peripheral unit.
// Assumes the enable changes only on the rising edge of clkIn.
`timescale 1ns/1ps
module unit_clock_gate (
  input wire logic clkIn, // Source clock
  input wire logic enable, // Clock pass enable
  output logic clkOut // Gated clock
);
  logic enLatch;

  // Latch is open while the clock is low, so the enable cannot chop a high phase
  always_latch begin
    if (!clkIn) begin
      enLatch <= enable;
    end
  end

  assign clkOut = clkIn & enLatch; // [R2] [R3]
endmodule

// ==== verif/deep_sleep_clock_gating_bank_chk.sv ====
// Checker for the clock gating bank: APB answer timing, fault timing, gated clocks.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
module deep_sleep_clock_gating_bank_chk
  import clk_gate_pkg::*;
#(
  parameter int UNITS = clk_gate_pkg::NUM_UNITS
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write
  input wire logic [clk_gate_pkg::ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [1:0] powerMode, // Power mode
  input wire logic [UNITS-1:0] periphSel, // Unit target
  input wire logic periphAccess, // Unit strobe
  input wire logic [UNITS-1:0] unitClkEn, // Enables
  input wire logic [UNITS-1:0] unitClk, // Gated clocks
  input wire logic periphFault // Fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Register port timing and reserved read bits
  sequence setupPhase;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (setupPhase |=> pready && psel && penable)
    else $error("no ready in access phase");
  a_ready_pulse_only: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_reserved_read_zero: assert property (pready && !pwrite && paddr == DEEP_GATE_OFS |->
    (prdata & ~GATE_WR_MASK) == 32'h0000_0000) else $error("reserved bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////////
  // Fault follows an access to a stopped unit by exactly one cycle
  a_fault_one_cycle: assert property (1'b1 |=> periphFault ==
    ($past(periphAccess) && |($past(periphSel) & ~$past(unitClkEn))))
    else $error("fault timing wrong");
  // Enables move only after a register access or a mode change
  a_enable_has_cause: assert property ($changed(unitClkEn) |-> $past(psel) || $past(psel, 2) ||
    $past(powerMode) != $past(powerMode, 2) || $past(powerMode, 2) != $past(powerMode, 3))
    else $error("enable changed without cause");

  ////////////////////////////////////////////////////////////////////////////////
  // Sampled in the high phase; an enable edge may land either side of the latch
  a_clock_passes: assert property (@(negedge clk) ((unitClkEn & $past(unitClkEn)) & ~unitClk) == '0)
    else $error("enabled unit lost its clock");
  a_clock_stopped: assert property (@(negedge clk) (unitClk & ~(unitClkEn | $past(unitClkEn))) == '0)
    else $error("disabled unit clocked");
endmodule

bind deep_sleep_clock_gating_bank deep_sleep_clock_gating_bank_chk #(.UNITS(UNITS)) chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerMode(powerMode), .periphSel(periphSel),
  .periphAccess(periphAccess), .unitClkEn(unitClkEn), .unitClk(unitClk), .periphFault(periphFault)
);

// ==== verif/deep_sleep_clock_gating_bank_test.sv ====
// Self-checking bench for the clock gating bank, over APB and the unit access port.
// Assumes the package constants; the bench drives every input itself.
`timescale 1ns/1ps
module deep_sleep_clock_gating_bank_test;
  import clk_gate_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, periphAccess = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] powerMode = 2'h0;
  logic [NUM_UNITS-1:0] periphSel = 12'h000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, periphFault, irq, err;
  logic [NUM_UNITS-1:0] unitClkEn, unitClk;
  int miscompares = 0;
  int checks = 0;
  int pos [12] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};

  always #10 clk = ~clk;

  deep_sleep_clock_gating_bank uut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerMode(powerMode), .periphSel(periphSel), .periphAccess(periphAccess), .unitClkEn(unitClkEn),
    .unitClk(unitClk), .periphFault(periphFault), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Set the power mode, let the enables settle, compare them
  task automatic mode(input logic [1:0] m, input logic [11:0] exp);
    @(posedge clk);
    powerMode <= m;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({20'h0, unitClkEn}, {20'h0, exp});
  endtask

  // One-cycle access strobe to unit u
  task automatic touch(input int u, input logic expFault);
    @(posedge clk);
    periphSel <= 12'h001 << u;
    periphAccess <= 1'b1;
    @(posedge clk);
    periphAccess <= 1'b0;
    @(negedge clk);
    check({31'h0, periphFault}, {31'h0, expFault});
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    apb(DEEP_GATE_OFS, 1'b0, 32'h0);
    check(rd, 32'h0000_0000);
    check({20'h0, unitClkEn}, 32'h0);
    apb(DEEP_GATE_OFS, 1'b1, 32'hFFFF_FFFF);
    apb(DEEP_GATE_OFS, 1'b0, 32'h0);
    check(rd, 32'h030F_5033);
    $display("test reset and reserved done");
    apb(RUN_GATE_OFS, 1'b1, 32'h0000_0001);
    apb(SLEEP_GATE_OFS, 1'b1, 32'h0200_0000);
    apb(CLK_CFG_OFS, 1'b1, 32'h0800_0000);
    mode(2'h2, 12'hFFF);
    mode(2'h1, 12'h800);
    mode(2'h0, 12'h001);
    apb(CLK_CFG_OFS, 1'b1, 32'h0);
    mode(2'h2, 12'h001);
    mode(2'h1, 12'h001);
    $display("test mode select done");
    apb(CLK_CFG_OFS, 1'b1, 32'h0800_0000);
    for (int i = 0; i < 12; i++) begin
      apb(DEEP_GATE_OFS, 1'b1, 32'h1 << pos[i]);
      apb(DEEP_GATE_OFS, 1'b0, 32'h0);
      check(rd, 32'h1 << pos[i]);
      mode(2'h2, 12'h001 << i);
      touch(i, 1'b0);
      touch((i + 1) % 12, 1'b1);
    end
    $display("test unit walk done");
    apb(IRQ_STATUS_OFS, 1'b1, 32'h3);
    apb(IRQ_MASK_OFS, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h0);
    touch(0, 1'b1);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h1);
    apb(IRQ_STATUS_OFS, 1'b0, 32'h0);
    check(rd, 32'h1);
    apb(IRQ_STATUS_OFS, 1'b1, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    pstrb <= 4'h1;
    apb(DEEP_GATE_OFS, 1'b1, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(EFFECTIVE_OFS, 1'b0, 32'h0);
    check(rd, 32'h0000_080F);
    apb(DEEP_GATE_OFS, 1'b0, 32'h0);
    check(rd, 32'h0200_0033);
    apb(12'h3FC, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test fault and interrupt done");
    end_of_test();
  end

  // Whole run is a few hundred cycles; this span is far beyond it
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule
